// ==== include/tc_regs_defs.svh ====
// Purpose: register offsets, field positions and reset values of the channel registers
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: definitions only
`ifndef TC_REGS_DEFS_SVH
`define TC_REGS_DEFS_SVH
`define OFS_MODE 8'h00
`define OFS_CV 8'h10
`define OFS_RA 8'h14
`define OFS_RB 8'h18
`define OFS_RC 8'h1C
`define OFS_SR 8'h20
`define OFS_IER 8'h24
`define OFS_IDR 8'h28
`define OFS_IMR 8'h2C
`define FLG_OVF 0
`define FLG_LOVR 1
`define FLG_MA 2
`define FLG_MB 3
`define FLG_MC 4
`define FLG_LDA 5
`define FLG_LDB 6
`define FLG_ETRG 7
`define SR_CLK 16
`define SR_LA 17
`define SR_LB 18
`define MASK_CAPTURE 8'hF3
`define MASK_WAVE 8'h9D
`define RST_FLAGS 8'h00
`define RST_IMASK 8'h00
`define RST_CMP 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== include/tc_regs_pkg.sv ====
// Purpose: state types of the channel register block
// Assumes: included after tc_regs_defs.svh
// Notes: types only
package tc_regs_pkg;
    typedef struct packed {
        logic [15:0] ra;
        logic [15:0] rb;
        logic [15:0] rc;
        logic [15:0] prev_count;
        logic [7:0] flags;
        logic [7:0] imask;
        logic wave;
        logic unread_a;
        logic unread_b;
        logic irq;
    } regs_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_s;
endpackage

// ==== include/reg_bus_if.sv ====
// Purpose: internal register access strobes between bus slave and register file
// Assumes: wr and rd are one-cycle pulses already gated by the clock enable
// Notes: rdata, rerr and werr answer in the same cycle as the strobe
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic werr;
    logic rd;
    logic [7:0] raddr;
    logic [31:0] rdata;
    logic rerr;
    modport bus_side (output wr, waddr, wdata, wstrb, rd, raddr, input werr, rdata, rerr);
    modport reg_side (input wr, waddr, wdata, wstrb, rd, raddr, output werr, rdata, rerr);
endinterface
`default_nettype wire

// ==== logic/tc_axil_slave.sv ====
// Purpose: AXI4-Lite slave turning bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes: write response one cycle after both address and data are held
`timescale 1ns/1ps
`include "tc_regs_defs.svh"
`default_nettype none
module tc_axil_slave (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    reg_bus_if.bus_side rb // register strobes
);
    tc_regs_pkg::axil_s q;
    tc_regs_pkg::axil_s n;

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    // write fires once address and data are both held
    assign rb.wr = clk_en && !q.awready && !q.wready && !q.bvalid && aresetn;
    assign rb.waddr = {q.awaddr[7:2], 2'h0};
    assign rb.wdata = q.wdata;
    assign rb.wstrb = q.wstrb;
    assign rb.rd = clk_en && q.arready && s_axi_arvalid && aresetn;
    assign rb.raddr = {s_axi_araddr[7:2], 2'h0};

    always_comb begin
        n = q;
        if (q.awready && s_axi_awvalid) begin
            n.awaddr = s_axi_awaddr;
            n.awready = 1'b0;
        end
        if (q.wready && s_axi_wvalid) begin
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
            n.wready = 1'b0;
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (rb.wr) begin
            n.bvalid = 1'b1;
            n.bresp = rb.werr ? `RESP_SLVERR : `RESP_OKAY;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
        if (rb.rd) begin
            n.rvalid = 1'b1;
            n.arready = 1'b0;
            n.rdata = rb.rdata;
            n.rresp = rb.rerr ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (!q.awready && !q.wready && !q.bvalid && !q.rvalid && !q.arready && q.awaddr == 8'hFF) begin
            n.awready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else if (clk_en) begin
            q <= n;
        end
    end
endmodule
`default_nettype wire

// ==== logic/tc_chan_regs.sv ====
// Purpose: software register side of one timer channel over AXI4-Lite
// Assumes: counting, capture and waveform datapath sit outside; inputs synchronous to aclk
// Notes: flags clear on status read, events in the same cycle survive the clear
// Functional notes
// - counter value reads live count, ignores writes
// - A and B writable only in waveform
// - register C always readable and writable
// - overflow flag, cleared by status read
// - load overrun flag, capture mode only
// - match A and B flags, waveform only
// - match C flag in both modes
// - load A and B flags, capture only
// - external trigger flag, clear on read
// - status shows counter clock running now
// - status mirrors line A by mode
// - status mirrors line B by mode
// - enable register sets mask bits on ones
// - disable register clears mask bits on ones
// - mask register reads current enables
// - mode bit: 0 capture, 1 waveform
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "tc_regs_defs.svh"
`default_nettype none
module tc_chan_regs #(
    parameter int COUNT_W = 16
) (
    input wire logic aclk, // clock, 50 MHz
    input wire logic aresetn, // sync reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [COUNT_W-1:0] live_count, // live counter value
    input wire logic overflow_evt, // counter overflow pulse
    input wire logic load_a_evt, // capture into A pulse
    input wire logic load_b_evt, // capture into B pulse
    input wire logic [COUNT_W-1:0] capture_value, // value captured
    input wire logic ext_trigger_evt, // external trigger pulse
    input wire logic clock_running, // counter clock enabled level
    input wire logic channel_line_a, // sampled pin level of line A
    input wire logic line_a_drive, // level driven on line A
    input wire logic channel_line_b, // sampled pin level of line B
    input wire logic line_b_drive, // level driven on line B
    output logic wave_mode, // 0 capture, 1 waveform
    output logic [COUNT_W-1:0] compare_a_value, // register A
    output logic [COUNT_W-1:0] compare_b_value, // register B
    output logic [COUNT_W-1:0] compare_c_value, // register C
    output logic chan_irq // channel interrupt, active high
);
    reg_bus_if rb ();
    tc_regs_pkg::regs_s q;
    tc_regs_pkg::regs_s n;
    logic [7:0] set_ev;
    logic rd_sr;
    logic line_a_mirror;
    logic line_b_mirror;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    tc_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rb(rb)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // flags that exist in the given mode
    function automatic logic [7:0] mode_mask(input logic wave);
        mode_mask = wave ? `MASK_WAVE : `MASK_CAPTURE;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == `OFS_MODE || a == `OFS_CV || a == `OFS_RA || a == `OFS_RB ||
                 a == `OFS_RC || a == `OFS_SR || a == `OFS_IER || a == `OFS_IDR ||
                 a == `OFS_IMR;
    endfunction

    assign wave_mode = q.wave;
    assign compare_a_value = q.ra;
    assign compare_b_value = q.rb;
    assign compare_c_value = q.rc;
    assign chan_irq = q.irq;
    assign line_a_mirror = q.wave ? line_a_drive : channel_line_a;
    assign line_b_mirror = q.wave ? line_b_drive : channel_line_b;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rb.rdata = 32'h0000_0000;
        rb.rerr = !mapped(rb.raddr);
        rb.werr = !mapped(rb.waddr);
        unique case (rb.raddr)
            `OFS_MODE: rb.rdata[0] = q.wave;
            `OFS_CV: rb.rdata[15:0] = live_count;
            `OFS_RA: rb.rdata[15:0] = q.ra;
            `OFS_RB: rb.rdata[15:0] = q.rb;
            `OFS_RC: rb.rdata[15:0] = q.rc;
            `OFS_SR: begin
                rb.rdata[7:0] = q.flags & mode_mask(q.wave);
                rb.rdata[`SR_CLK] = clock_running;
                rb.rdata[`SR_LA] = line_a_mirror;
                rb.rdata[`SR_LB] = line_b_mirror;
            end
            `OFS_IMR: rb.rdata[7:0] = q.imask;
            default: rb.rdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        rd_sr = rb.rd && rb.raddr == `OFS_SR;
        n.prev_count = live_count;
        set_ev = 8'h00;
        set_ev[`FLG_OVF] = overflow_evt;
        set_ev[`FLG_LOVR] = (load_a_evt && q.unread_a) || (load_b_evt && q.unread_b);
        set_ev[`FLG_MA] = live_count != q.prev_count && live_count == q.ra;
        set_ev[`FLG_MB] = live_count != q.prev_count && live_count == q.rb;
        set_ev[`FLG_MC] = live_count != q.prev_count && live_count == q.rc;
        set_ev[`FLG_LDA] = load_a_evt;
        set_ev[`FLG_LDB] = load_b_evt;
        set_ev[`FLG_ETRG] = ext_trigger_evt;
        set_ev = set_ev & mode_mask(q.wave);
        // set wins over the clear of a status read
        n.flags = (q.flags & ~{8{rd_sr}} & mode_mask(q.wave)) | set_ev;
        // a read of A or B marks it as seen
        if (rb.rd && rb.raddr == `OFS_RA) begin
            n.unread_a = 1'b0;
        end
        if (rb.rd && rb.raddr == `OFS_RB) begin
            n.unread_b = 1'b0;
        end
        if (!q.wave && load_a_evt) begin
            n.ra = capture_value;
            n.unread_a = 1'b1;
        end
        if (!q.wave && load_b_evt) begin
            n.rb = capture_value;
            n.unread_b = 1'b1;
        end
        if (rb.wr) begin
            unique case (rb.waddr)
                `OFS_MODE: begin
                    if (rb.wstrb[0]) begin
                        n.wave = rb.wdata[0];
                    end
                end
                `OFS_RA: begin
                    if (q.wave) begin
                        n.ra = merge16(q.ra, rb.wdata, rb.wstrb);
                    end
                end
                `OFS_RB: begin
                    if (q.wave) begin
                        n.rb = merge16(q.rb, rb.wdata, rb.wstrb);
                    end
                end
                `OFS_RC: n.rc = merge16(q.rc, rb.wdata, rb.wstrb);
                `OFS_IER: begin
                    if (rb.wstrb[0]) begin
                        n.imask = q.imask | rb.wdata[7:0];
                    end
                end
                `OFS_IDR: begin
                    if (rb.wstrb[0]) begin
                        n.imask = q.imask & ~rb.wdata[7:0];
                    end
                end
                default: n.imask = q.imask;
            endcase
        end
        n.irq = |(n.flags & n.imask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.flags <= `RST_FLAGS;
            q.imask <= `RST_IMASK;
            q.ra <= `RST_CMP;
            q.rb <= `RST_CMP;
            q.rc <= `RST_CMP;
        end else if (clk_en) begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    cv_readback_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rb.rd && rb.raddr == `OFS_CV |-> rb.rdata == {16'h0000, live_count})
        else $error("counter value read mismatch");

    ra_capture_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rb.wr && rb.waddr == `OFS_RA && !q.wave && !load_a_evt |=> $stable(q.ra))
        else $error("register A written in capture mode");

    rc_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rb.wr && rb.waddr == `OFS_RC && rb.wstrb == 4'hF
        |=> q.rc == $past(rb.wdata[15:0]))
        else $error("register C write lost");

    sr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rd_sr && set_ev == 8'h00 |=> q.flags == 8'h00)
        else $error("status flags not cleared by read");

    ovf_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && overflow_evt && rd_sr |=> q.flags[`FLG_OVF])
        else $error("overflow lost on status read");

    overrun_wave_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_sr && q.wave |-> rb.rdata[`FLG_LOVR] == 1'b0 && rb.rdata[`FLG_LDA] == 1'b0)
        else $error("capture flag visible in waveform mode");

    match_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_sr && !q.wave |-> rb.rdata[`FLG_MA] == 1'b0 && rb.rdata[`FLG_MB] == 1'b0)
        else $error("match flag visible in capture mode");

    match_c_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && live_count != q.prev_count && live_count == q.rc |=> q.flags[`FLG_MC])
        else $error("match C flag not set");

    load_a_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && load_a_evt && !q.wave |=> q.flags[`FLG_LDA] && q.ra == $past(capture_value))
        else $error("load A not recorded");

    trig_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && ext_trigger_evt |=> q.flags[`FLG_ETRG])
        else $error("external trigger flag not set");

    clk_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_sr |-> rb.rdata[`SR_CLK] == clock_running)
        else $error("clock status wrong");

    mirror_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_sr && q.wave |-> rb.rdata[`SR_LA] == line_a_drive)
        else $error("line A mirror wrong");

    mirror_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_sr && !q.wave |-> rb.rdata[`SR_LB] == channel_line_b)
        else $error("line B mirror wrong");

    ier_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rb.wr && rb.waddr == `OFS_IER && rb.wstrb[0]
        |=> q.imask == ($past(q.imask) | $past(rb.wdata[7:0])))
        else $error("enable register did not set mask");

    idr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && rb.wr && rb.waddr == `OFS_IDR && rb.wstrb[0]
        |=> q.imask == ($past(q.imask) & ~$past(rb.wdata[7:0])))
        else $error("disable register did not clear mask");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        chan_irq == |(q.flags & q.imask))
        else $error("interrupt does not follow flags and mask");
endmodule
`default_nettype wire

// ==== verification/tc_chan_regs_test.sv ====
// Purpose: self-checking bench of the timer channel register block
// Assumes: one write and one read at a time, clock enable held high
// Notes: bus tasks sample at the falling edge and act at the next rising edge
`timescale 1ns/1ps
`default_nettype none
module tc_chan_regs_test;
    // ------------------------------------------------------------
    // address map and stimulus signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_MODE = 8'h00, A_CNT = 8'h10, A_CPA = 8'h14, A_CPB = 8'h18;
    localparam logic [7:0] A_CPC = 8'h1C, A_STAT = 8'h20, A_IEN = 8'h24, A_IDIS = 8'h28;
    localparam logic [7:0] A_IMSK = 8'h2C, A_BAD = 8'h30;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ovf, lda, ldb, ext, clk_run;
    logic pin_a, drv_a, pin_b, drv_b, wave, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] count, cap, cmp_a, cmp_b, cmp_c;
    logic [3:0] wstrb;
    int err_count, checks_done;

    tc_chan_regs #(.COUNT_W(16)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .live_count(count), .overflow_evt(ovf),
        .load_a_evt(lda), .load_b_evt(ldb), .capture_value(cap), .ext_trigger_evt(ext),
        .clock_running(clk_run), .channel_line_a(pin_a), .line_a_drive(drv_a),
        .channel_line_b(pin_b), .line_b_drive(drv_b), .wave_mode(wave),
        .compare_a_value(cmp_a), .compare_b_value(cmp_b), .compare_c_value(cmp_c),
        .chan_irq(irq));

    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hung;
        err_count++;
        $display("Error bus answer expected within 100 cycles seen none");
        report_and_stop();
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        hung();
    endtask

    // evt raises an external trigger at the edge that takes the read address
    task automatic bus_rd(input logic [7:0] a, input logic evt);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ext <= evt;
        for (int n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            ext <= 1'b0;
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        hung();
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus_rd(a, 1'b0);
        chk(what, exp, rd);
    endtask

    task automatic pulse(input int k, input logic [15:0] v);
        @(posedge aclk);
        cap <= v;
        ovf <= (k == 0);
        lda <= (k == 1);
        ldb <= (k == 2);
        ext <= (k == 3);
        @(posedge aclk);
        {ovf, lda, ldb, ext} <= 4'h0;
    endtask

    task automatic irq_after(input logic exp);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk("chan_irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdc("reg a", A_CPA, 32'h0000_0000);
        rdc("reg c", A_CPC, 32'h0000_0000);
        rdc("mode", A_MODE, 32'h0000_0000);
        rdc("mask", A_IMSK, 32'h0000_0000);
        rdc("status", A_STAT, 32'h0003_0000);
        $display("test reset done");
    endtask

    task automatic t_count_bad;
        @(posedge aclk);
        count <= 16'hA5C3;
        rdc("count", A_CNT, 32'h0000_A5C3);
        bus_wr(A_CNT, 32'hFFFF_FFFF);
        chk("ignored write resp", 32'h0, {30'h0, rs});
        rdc("count kept", A_CNT, 32'h0000_A5C3);
        bus_wr(A_BAD, 32'h0000_0001);
        chk("bad write resp", 32'h2, {30'h0, rs});
        bus_rd(A_BAD, 1'b0);
        chk("bad read resp", 32'h2, {30'h0, rs});
        $display("test count done");
    endtask

    task automatic t_capture;
        bus_wr(A_CPA, 32'h0000_1111);
        rdc("reg a locked", A_CPA, 32'h0000_0000);
        bus_wr(A_CPC, 32'h0000_0042);
        pulse(1, 16'h1111);
        pulse(1, 16'h2222);
        pulse(2, 16'h3333);
        rdc("status capture", A_STAT, 32'h0003_0062);
        rdc("status cleared", A_STAT, 32'h0003_0000);
        rdc("reg a loaded", A_CPA, 32'h0000_2222);
        chk("reg b out", 32'h0000_3333, {16'h0, cmp_b});
        $display("test capture done");
    endtask

    task automatic t_wave;
        @(posedge aclk);
        count <= 16'h003F;
        clk_run <= 1'b0;
        bus_wr(A_MODE, 32'h0000_0001);
        chk("wave mode", 32'h1, {31'h0, wave});
        bus_wr(A_CPA, 32'h0000_0040);
        bus_wr(A_CPB, 32'h0000_0041);
        rdc("reg a wave", A_CPA, 32'h0000_0040);
        rdc("reg b wave", A_CPB, 32'h0000_0041);
        chk("reg a out", 32'h0000_0040, {16'h0, cmp_a});
        rdc("reg c", A_CPC, 32'h0000_0042);
        chk("reg c out", 32'h0000_0042, {16'h0, cmp_c});
        for (int v = 16'h40; v <= 16'h42; v++) begin
            @(posedge aclk);
            count <= v[15:0];
        end
        pulse(0, 16'h0);
        pulse(3, 16'h0);
        pulse(1, 16'h5555);
        rdc("status wave", A_STAT, 32'h0004_009D);
        rdc("status cleared", A_STAT, 32'h0004_0000);
        $display("test waveform done");
    endtask

    task automatic t_irq;
        bus_wr(A_IEN, 32'h0000_0001);
        bus_wr(A_IEN, 32'h0000_0080);
        rdc("mask set", A_IMSK, 32'h0000_0081);
        bus_wr(A_IDIS, 32'h0000_0001);
        rdc("mask cleared", A_IMSK, 32'h0000_0080);
        pulse(0, 16'h0);
        irq_after(1'b0);
        pulse(3, 16'h0);
        irq_after(1'b1);
        rdc("status irq", A_STAT, 32'h0004_0081);
        irq_after(1'b0);
        bus_rd(A_STAT, 1'b1);
        rdc("event kept", A_STAT, 32'h0004_0080);
        $display("test interrupt done");
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, ovf, lda, ldb, ext} = 9'h000;
        {clk_run, pin_a, drv_a, pin_b, drv_b} = 5'b11001;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        count = 16'h0000;
        cap = 16'h0000;
        err_count = 0;
        checks_done = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_count_bad();
        t_capture();
        t_wave();
        t_irq();
        report_and_stop();
    end
endmodule
`default_nettype wire
